/* inc/bphc_map.svh */
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Core clock of 100 MHz; byte addresses on the register bus.
// Notes: Definitions only; included by bare name.
`ifndef BPHC_MAP_SVH
`define BPHC_MAP_SVH

// Core clock rate and a rounding-up conversion from ns to clock cycles.
`define BPHC_CLK_MHZ 100
`define BPHC_NS2CYC(ns) ((((ns) * `BPHC_CLK_MHZ) + 999) / 1000)

// Leading-edge blanking times per select state, in ns and in cycles.
`define BPHC_BLANK_GND_NS 120
`define BPHC_BLANK_OPEN_NS 160
`define BPHC_BLANK_RAIL_NS 200
`define BPHC_BLANK_GND_CYC `BPHC_NS2CYC(`BPHC_BLANK_GND_NS)
`define BPHC_BLANK_OPEN_CYC `BPHC_NS2CYC(`BPHC_BLANK_OPEN_NS)
`define BPHC_BLANK_RAIL_CYC `BPHC_NS2CYC(`BPHC_BLANK_RAIL_NS)

// Maximum duty cycle per select state, in percent.
`define BPHC_DUTY_GND_PCT 96
`define BPHC_DUTY_OPEN_PCT 84
`define BPHC_DUTY_RAIL_PCT 75

// Oscillator ticks per switching period and the half-period phase shift.
`define BPHC_OSC_MULT 12
`define BPHC_PHASE_SHIFT 6

// Hiccup entry count and overcurrent-free periods that clear it.
`define BPHC_OC_LIMIT 16
`define BPHC_CLEAR_PERIODS 2

// Register byte offsets.
`define BPHC_OFS_CTRL 5'h00
`define BPHC_OFS_DIV 5'h04
`define BPHC_OFS_STATUS 5'h08
`define BPHC_OFS_IRQ_STAT 5'h0c
`define BPHC_OFS_IRQ_MASK 5'h10

// Reset values.
`define BPHC_CTRL_RST 2'h0
`define BPHC_DIV_RST 16'h0018
`define BPHC_MASK_RST 6'h00

// Event bit positions in the interrupt status and mask registers.
`define BPHC_EV_HICCUP 0
`define BPHC_EV_OV 2
`define BPHC_EV_RECOVER 4

// Status field positions.
`define BPHC_ST_HICCUP 0
`define BPHC_ST_SKIP 2
`define BPHC_ST_GATE 4
`define BPHC_ST_OC0 8
`define BPHC_ST_OC1 16

`endif

/* inc/bphc_pkg.sv */
// Purpose: Types shared by the boost timing and hiccup controller.
// Assumes: Two channels, each carried as one packed struct per direction.
// Notes: Numeric constants live in bphc_map.svh.
package bphc_pkg;

  // Three-state select pin, already resolved to a code by the pad logic.
  typedef enum logic [1:0]
  {
    BPHC_SEL_GND = 2'h0,
    BPHC_SEL_OPEN = 2'h1,
    BPHC_SEL_RAIL = 2'h2
  } bphc_sel_t;

  // Per-channel protection state, one-hot.
  typedef enum logic [1:0]
  {
    BPHC_RUN = 2'b01,
    BPHC_HICCUP = 2'b10
  } bphc_state_t;

  // Comparator and soft-start levels arriving for one channel.
  typedef struct packed
  {
    logic cur_trip;
    logic ov_flag;
    logic ea_at_clamp;
    logic ss_active;
    logic ss_zero;
    logic ea_below_skip;
    logic ea_above_skip_hys;
  } bphc_ch_in_t;

  // Drive signals leaving for one channel.
  typedef struct packed
  {
    logic gate;
    logic ea_pulldown;
    logic ss_sink;
    logic ss_restart;
    logic soft_recover;
  } bphc_ch_out_t;

endpackage

/* hw/bphc_ctrl.sv */
// Purpose: Switching-period timing, blanking, duty limit and hiccup logic.
// Assumes: Comparator levels are synchronous to core_clk_i.
// Notes: Registers sit on an Avalon-MM slave that answers in two cycles.
`timescale 1ns/1ps
`default_nettype none
`include "bphc_map.svh"

// What this block does
// - Blanking of 120, 160 or 200 ns follows the blank select pin.
// - Gate stays on at least the blanking interval after turning on, unless protection or a disable ends it.
// - Current comparator trips are ignored during blanking.
// - Maximum duty of 96, 84 or 75 percent follows the duty select pin.
// - Base oscillator runs at twelve times switching rate, divided down.
// - Duty limit comes purely from divider count values.
// - Gate is held off while the overvoltage flag stands.
// - A period is overcurrent when error amp output reaches its clamp.
// - Sixteen consecutive overcurrent periods enter hiccup mode.
// - Hiccup pulls error amp output to ground and holds gate off.
// - Hiccup discharges soft-start with a small 1.25 uA sink.
// - Soft-start at zero volts releases error amp and restarts.
// - Hiccup is never entered while soft-start is running.
// - Two clean periods before sixteen clear the count, soft recover.
// - Error amp below 0.5 V makes the channel skip cycles.
// - Skipping stops only 50 mV above the skip threshold.
module bphc_ctrl
  import bphc_pkg::*;
#(
  parameter int OC_LIMIT = `BPHC_OC_LIMIT,
  parameter int CLEAR_PERIODS = `BPHC_CLEAR_PERIODS,
  parameter logic [15:0] DIV_RESET = `BPHC_DIV_RST
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire bphc_sel_t blank_sel_i,
  input wire bphc_sel_t dmax_sel_i,
  input wire bphc_ch_in_t [1:0] ch_in_i,
  output bphc_ch_out_t [1:0] ch_out_o,
  output logic irq_o
);

  // Refuse counts the counter widths cannot hold.
  if (OC_LIMIT < 2 || OC_LIMIT > 31)
  begin : g_chk_oc
    $error("OC_LIMIT must lie between 2 and 31");
  end
  if (CLEAR_PERIODS < 1 || CLEAR_PERIODS > 3)
  begin : g_chk_clr
    $error("CLEAR_PERIODS must lie between 1 and 3");
  end

  // Blanking length in cycles for a select code; a stray code reads as open.
  function automatic logic [7:0] bphc_blank_cyc(input bphc_sel_t sel);
    logic [7:0] cyc;
    cyc = 8'(`BPHC_BLANK_OPEN_CYC);
    if (sel == BPHC_SEL_GND)
      cyc = 8'(`BPHC_BLANK_GND_CYC);
    else if (sel == BPHC_SEL_RAIL)
      cyc = 8'(`BPHC_BLANK_RAIL_CYC);
    return cyc;
  endfunction

  // Duty limit percentage for a select code; a stray code reads as open.
  function automatic logic [6:0] bphc_duty_pct(input bphc_sel_t sel);
    logic [6:0] pct;
    pct = 7'(`BPHC_DUTY_OPEN_PCT);
    if (sel == BPHC_SEL_GND)
      pct = 7'(`BPHC_DUTY_GND_PCT);
    else if (sel == BPHC_SEL_RAIL)
      pct = 7'(`BPHC_DUTY_RAIL_PCT);
    return pct;
  endfunction

  // True once the position in the period reaches pct percent of it.
  // Exact integer math keeps the limit free of any rounding drift.
  function automatic logic bphc_duty_hit(input logic [31:0] pos,
                                         input logic [15:0] div,
                                         input logic [6:0] pct);
    logic [47:0] lhs;
    logic [47:0] rhs;
    lhs = 48'(pos) * 48'h0064;
    rhs = 48'(div) * 48'(`BPHC_OSC_MULT) * 48'(pct);
    return lhs >= rhs;
  endfunction

  logic [1:0] ch_en;
  logic [15:0] osc_div;
  logic [5:0] irq_stat;
  logic [5:0] irq_mask;
  logic bus_ack;
  logic [15:0] sub_cnt;
  logic [3:0] tick_idx;
  wire logic [5:0] ev;
  wire logic [1:0] st_hic;
  wire logic [1:0] st_skip;
  wire logic [1:0] st_gate;
  wire logic [4:0] st_oc [2];

  // Shared selections and the effective divider, zero read as one.
  wire logic [7:0] blank_cyc = bphc_blank_cyc(blank_sel_i);
  wire logic [6:0] duty_pct = bphc_duty_pct(dmax_sel_i);
  wire logic [15:0] div_eff = (osc_div == 16'h0000) ? 16'h0001 : osc_div;
  wire logic sub_last = (sub_cnt >= div_eff - 16'h0001);
  wire logic [3:0] idx_next = (tick_idx == 4'(`BPHC_OSC_MULT - 1)) ?
                              4'h0 : tick_idx + 4'h1;

  // Oscillator: sub_cnt makes the twelve-times tick, tick_idx divides it.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      sub_cnt <= 16'h0000;
      tick_idx <= 4'h0;
    end
    else if (sub_last)
    begin
      sub_cnt <= 16'h0000;
      tick_idx <= idx_next;
    end
    else
      sub_cnt <= sub_cnt + 16'h0001;
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    bphc_state_t state;
    logic gate;
    logic [7:0] on_cnt;
    logic [4:0] oc_cnt;
    logic [1:0] clr_cnt;
    logic oc_seen;
    logic skip;
    logic ov_d;
    logic restart;
    logic recover;
    bphc_ch_in_t in;

    assign in = ch_in_i[c];

    // Channel two runs half a period behind channel one.
    wire logic [3:0] tidx = (c == 0) ? tick_idx :
                            (tick_idx >= 4'(`BPHC_PHASE_SHIFT)) ?
                            tick_idx - 4'(`BPHC_PHASE_SHIFT) :
                            tick_idx + 4'(`BPHC_PHASE_SHIFT);
    wire logic [31:0] pos = 32'(tidx) * 32'(div_eff) + 32'(sub_cnt);
    wire logic start = (tidx == 4'h0) && (sub_cnt == 16'h0000);
    wire logic run = (state == BPHC_RUN);
    wire logic duty_hit = bphc_duty_hit(pos, div_eff, duty_pct);
    wire logic blank_done = (on_cnt >= blank_cyc);

    // Period bookkeeping evaluated at each period start.
    wire logic [4:0] oc_inc = (oc_cnt == 5'(OC_LIMIT)) ?
                              oc_cnt : oc_cnt + 5'h01;
    wire logic [1:0] clr_inc = (clr_cnt == 2'h3) ? clr_cnt : clr_cnt + 2'h1;
    // A count that reaches its limit during soft-start is held there, so
    // the first overcurrent period after soft-start ends enters hiccup.
    wire logic enter_hic = start && run && oc_seen && !in.ss_active &&
                           (oc_inc == 5'(OC_LIMIT));
    wire logic clear_oc = start && run && !oc_seen && (oc_cnt != 5'h00) &&
                          (clr_inc >= 2'(CLEAR_PERIODS));
    wire logic leave_hic = !run && in.ss_zero;

    // Gate on at period start; protection ends it at once, while the
    // current trip and the duty limit wait for blanking to finish.
    // Limitation: with a small divider the blanking can outlast the duty
    // limit, and then the minimum on-time wins over the duty limit.
    wire logic gate_set = start && ch_en[c] && run && !skip &&
                          !in.ov_flag && !enter_hic;
    wire logic gate_clr = in.ov_flag || !run || enter_hic || !ch_en[c] ||
                          (blank_done && in.cur_trip) ||
                          (blank_done && duty_hit);

    // Protection state: hiccup is left only through the soft-start node.
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        state <= BPHC_RUN;
      else
      begin
        case (state)
          BPHC_RUN:
          begin
            if (enter_hic)
              state <= BPHC_HICCUP;
          end
          BPHC_HICCUP:
          begin
            if (leave_hic)
              state <= BPHC_RUN;
          end
          default:
            state <= BPHC_RUN;
        endcase
      end
    end

    // A period counts as overcurrent if the clamp was hit at any time in it.
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        oc_seen <= 1'b0;
      else if (start)
        oc_seen <= in.ea_at_clamp;
      else if (in.ea_at_clamp)
        oc_seen <= 1'b1;
    end

    // Consecutive overcurrent periods; clean periods tally toward a clear.
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i || leave_hic || clear_oc)
      begin
        oc_cnt <= 5'h00;
        clr_cnt <= 2'h0;
      end
      else if (start && run && oc_seen)
      begin
        oc_cnt <= oc_inc;
        clr_cnt <= 2'h0;
      end
      else if (start && run)
        clr_cnt <= clr_inc;
    end

    // Gate flop and on-time counter for blanking.
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        gate <= 1'b0;
      else if (gate_set)
        gate <= 1'b1;
      else if (gate_clr)
        gate <= 1'b0;
    end

    always_ff @(posedge core_clk_i)
    begin
      if (rst_i || gate_set)
        on_cnt <= 8'h00;
      else if (gate && on_cnt != 8'hff)
        on_cnt <= on_cnt + 8'h01;
    end

    // Skip comparator with hysteresis: set low, release only well above.
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
        skip <= 1'b0;
      else if (in.ea_below_skip)
        skip <= 1'b1;
      else if (in.ea_above_skip_hys)
        skip <= 1'b0;
    end

    // One-cycle pulses and the overvoltage edge detector.
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
      begin
        restart <= 1'b0;
        recover <= 1'b0;
        ov_d <= 1'b0;
      end
      else
      begin
        restart <= leave_hic;
        recover <= clear_oc;
        ov_d <= in.ov_flag;
      end
    end

    // Drive outputs straight from flops; hiccup drives pull-down and sink.
    assign ch_out_o[c].gate = gate;
    assign ch_out_o[c].ea_pulldown = !run;
    assign ch_out_o[c].ss_sink = !run;
    assign ch_out_o[c].ss_restart = restart;
    assign ch_out_o[c].soft_recover = recover;

    // Events and status for the register file.
    assign ev[`BPHC_EV_HICCUP + c] = enter_hic;
    assign ev[`BPHC_EV_OV + c] = in.ov_flag && !ov_d;
    assign ev[`BPHC_EV_RECOVER + c] = clear_oc;
    assign st_hic[c] = !run;
    assign st_skip[c] = skip;
    assign st_gate[c] = gate;
    assign st_oc[c] = oc_cnt;
  end

  // Bus decode. The first request cycle stalls, the second completes,
  // which gives read data a full cycle to settle from a flop.
  // A master that keeps its request up after the answer starts a new
  // transfer, so each request must be dropped once it has been answered.
  wire logic bus_req = avs_read_i || avs_write_i;
  wire logic wr_go = avs_write_i && bus_ack;
  wire logic sel_ctrl = (avs_address_i == `BPHC_OFS_CTRL);
  wire logic sel_div = (avs_address_i == `BPHC_OFS_DIV);
  wire logic sel_stat = (avs_address_i == `BPHC_OFS_STATUS);
  wire logic sel_ist = (avs_address_i == `BPHC_OFS_IRQ_STAT);
  wire logic sel_imsk = (avs_address_i == `BPHC_OFS_IRQ_MASK);
  wire logic lane0 = avs_byteenable_i[0];
  wire logic lane1 = avs_byteenable_i[1];
  wire logic [5:0] ist_clr = (wr_go && sel_ist && lane0) ?
                             avs_writedata_i[5:0] : 6'h00;

  // Live status word.
  wire logic [31:0] status_word = {11'h000, st_oc[1], 3'h0, st_oc[0],
                                   2'h0, st_gate, st_skip, st_hic};

  // Read mux; unmapped addresses read as zero.
  wire logic [31:0] rd_mux =
    sel_ctrl ? {30'h0000_0000, ch_en} :
    sel_div ? {16'h0000, osc_div} :
    sel_stat ? status_word :
    sel_ist ? {26'h000_0000, irq_stat} :
    sel_imsk ? {26'h000_0000, irq_mask} :
    32'h0000_0000;

  assign avs_waitrequest_o = bus_req && !bus_ack;
  assign irq_o = |(irq_stat & irq_mask);

  // Handshake and read capture.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      bus_ack <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else
    begin
      bus_ack <= bus_req && !bus_ack;
      if (avs_read_i && !bus_ack)
        avs_readdata_o <= rd_mux;
    end
  end

  // Writable registers; writes to unmapped addresses are dropped.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ch_en <= `BPHC_CTRL_RST;
      osc_div <= DIV_RESET;
      irq_mask <= `BPHC_MASK_RST;
    end
    else if (wr_go)
    begin
      if (sel_ctrl && lane0)
        ch_en <= avs_writedata_i[1:0];
      if (sel_div && lane0)
        osc_div[7:0] <= avs_writedata_i[7:0];
      if (sel_div && lane1)
        osc_div[15:8] <= avs_writedata_i[15:8];
      if (sel_imsk && lane0)
        irq_mask <= avs_writedata_i[5:0];
    end
  end

  // Sticky events: a set in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      irq_stat <= 6'h00;
    else
      irq_stat <= (irq_stat & ~ist_clr) | ev;
  end

endmodule
`default_nettype wire

/* bench/bphc_checker.sv */
// Purpose: Port-level checks of gate timing and hiccup on channel 0.
// Assumes: DIV stays at its reset value, so a period is 12 * DIV_RESET.
// Notes: The channel enable is never dropped in mid-pulse by the bench.
`timescale 1ns/1ps
`default_nettype none
`include "bphc_map.svh"
module bphc_checker
  import bphc_pkg::*;
#(
  parameter logic [15:0] DIV_RESET = `BPHC_DIV_RST
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire bphc_sel_t blank_sel_i,
  input wire bphc_sel_t dmax_sel_i,
  input wire bphc_ch_in_t [1:0] ch_in_i,
  input wire bphc_ch_out_t [1:0] ch_out_o
);
  localparam int PER = 12 * DIV_RESET;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Channel 0 views and the selected limits, in cycles.
  wire logic g = ch_out_o[0].gate;
  wire logic pd = ch_out_o[0].ea_pulldown;
  wire bphc_ch_in_t ci = ch_in_i[0];
  wire logic [31:0] blank = blank_sel_i == BPHC_SEL_RAIL ?
    `BPHC_BLANK_RAIL_CYC : blank_sel_i == BPHC_SEL_GND ?
    `BPHC_BLANK_GND_CYC : `BPHC_BLANK_OPEN_CYC;
  wire logic [31:0] pct = dmax_sel_i == BPHC_SEL_RAIL ?
    `BPHC_DUTY_RAIL_PCT : dmax_sel_i == BPHC_SEL_GND ?
    `BPHC_DUTY_GND_PCT : `BPHC_DUTY_OPEN_PCT;
  wire logic [31:0] dlen = (PER * pct + 99) / 100;
  logic [15:0] on_len;
  logic [15:0] since;
  logic seen;
  // Gate run length and spacing of rises; wide so a hiccup sleep
  // cannot wrap the spacing counter.
  always_ff @(posedge core_clk_i)
  begin
    on_len <= (g && !rst_i) ? on_len + 16'h0001 : 16'h0000;
    since <= $rose(g) ? 16'h0000 : since + 16'h0001;
    seen <= !rst_i && (seen || $rose(g));
  end
  property p_ov_off;
    ci.ov_flag |=> !g;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("gate on in ov");
  property p_min_on;
    $fell(g) && !$past(ci.ov_flag) && !pd && !$past(pd)
      |-> $past(on_len) >= $past(blank);
  endproperty
  a_min_on: assert property (p_min_on) else $error("pulse short");
  property p_duty;
    g |-> on_len < dlen;
  endproperty
  a_duty: assert property (p_duty) else $error("duty too long");
  property p_period;
    $rose(g) && seen |-> (since + 16'h0001) % PER == 0;
  endproperty
  a_period: assert property (p_period) else $error("off grid");
  property p_hic_off;
    pd [*2] |-> !g;
  endproperty
  a_hic_off: assert property (p_hic_off) else $error("gate in hiccup");
  property p_sink;
    pd |-> ch_out_o[0].ss_sink;
  endproperty
  a_sink: assert property (p_sink) else $error("no sink");
  property p_restart;
    pd && ci.ss_zero |=> ch_out_o[0].ss_restart && !pd
      ##1 !ch_out_o[0].ss_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no retry");
  property p_ss_entry;
    $rose(pd) |-> !$past(ci.ss_active);
  endproperty
  a_ss_entry: assert property (p_ss_entry) else $error("entry in ss");
endmodule
bind bphc_ctrl bphc_checker #(
  .DIV_RESET(DIV_RESET)
) chk_u (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .blank_sel_i(blank_sel_i),
  .dmax_sel_i(dmax_sel_i),
  .ch_in_i(ch_in_i),
  .ch_out_o(ch_out_o)
);
`default_nettype wire

/* bench/bphc_plant.sv */
// Purpose: Far side: power switch, sense comparators, soft-start node.
// Assumes: Knobs steer channel 0, but trip_i trips both; channel 1 otherwise runs clean, above the skip.
// Notes: Current trips trip_i gate-on cycles after turn-on, 0 never.
`timescale 1ns/1ps
`default_nettype none
module bphc_plant
  import bphc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire bphc_ch_out_t [1:0] ch_out_i,
  input wire logic oc_i,
  input wire logic ov_i,
  input wire logic hold_i,
  input wire logic low_i,
  input wire logic hys_i,
  input wire logic [7:0] trip_i,
  output bphc_ch_in_t [1:0] ch_in_o
);
  logic [7:0] on_c [2];
  logic [7:0] ss_c [2];
  logic [7:0] dr_c [2];
  for (genvar c = 0; c < 2; c++)
  begin
    wire logic k = c == 0;
    // The cap charges 48 cycles after a retry and needs 40 to drain,
    // so a fitted cap always gives the sleep a finite length.
    always_ff @(posedge core_clk_i)
    begin
      on_c[c] <= (ch_out_i[c].gate && !rst_i) ? on_c[c] + 8'h01 : 8'h00;
      ss_c[c] <= rst_i ? 8'h00 : ch_out_i[c].ss_restart ? 8'h30 :
        ss_c[c] - {7'h00, ss_c[c] != 8'h00};
      dr_c[c] <= (rst_i || !ch_out_i[c].ss_sink) ? 8'h28 :
        dr_c[c] - {7'h00, dr_c[c] != 8'h00};
    end
    // Comparator levels presented to the design.
    assign ch_in_o[c].cur_trip = trip_i != 8'h00 && on_c[c] >= trip_i;
    assign ch_in_o[c].ov_flag = k && ov_i;
    assign ch_in_o[c].ea_at_clamp = k && oc_i;
    assign ch_in_o[c].ss_active = (k && hold_i) || ss_c[c] != 8'h00;
    assign ch_in_o[c].ss_zero = ch_out_i[c].ss_sink && dr_c[c] == 8'h00;
    assign ch_in_o[c].ea_below_skip = k && low_i;
    assign ch_in_o[c].ea_above_skip_hys = !k || hys_i;
  end
endmodule
`default_nettype wire

/* bench/boost_pwm_timing_hiccup_ctrl_bench.sv */
// Purpose: Self-checking bench for the boost timing and hiccup block.
// Assumes: DIV left at three, so a switching period is 36 cycles.
// Notes: Pulse widths are read as gate-high cycles over whole periods.
`timescale 1ns/1ps
`default_nettype none
`include "bphc_map.svh"
module boost_pwm_timing_hiccup_ctrl_bench
  import bphc_pkg::*;
;
  localparam int PER = 36;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdo;
  logic [31:0] rv;
  logic wq;
  logic irq;
  bphc_sel_t sel = BPHC_SEL_GND;
  bphc_ch_in_t [1:0] ch_in;
  bphc_ch_out_t [1:0] ch_out;
  logic oc = 1'h0;
  logic ov = 1'h0;
  logic hold = 1'h0;
  logic low = 1'h0;
  logic hys = 1'h1;
  logic [7:0] trip = 8'h00;
  int n_fail = 0;
  int n_checks = 0;
  int hi, hi1, pdc, rec, fpd;
  int pct[3] = '{`BPHC_DUTY_GND_PCT, `BPHC_DUTY_OPEN_PCT,
    `BPHC_DUTY_RAIL_PCT};
  int blk[3] = '{`BPHC_BLANK_GND_CYC, `BPHC_BLANK_OPEN_CYC,
    `BPHC_BLANK_RAIL_CYC};
  // Core clock of 100 MHz.
  always #5 clk = ~clk;
  bphc_ctrl #(.DIV_RESET(16'h0003)) dut_u (
    .core_clk_i(clk),
    .rst_i(rst),
    .avs_address_i(addr),
    .avs_read_i(rd),
    .avs_write_i(wr),
    .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdo),
    .avs_waitrequest_o(wq),
    .blank_sel_i(sel),
    .dmax_sel_i(sel),
    .ch_in_i(ch_in),
    .ch_out_o(ch_out),
    .irq_o(irq)
  );
  bphc_plant plant_u (
    .core_clk_i(clk),
    .rst_i(rst),
    .ch_out_i(ch_out),
    .oc_i(oc),
    .ov_i(ov),
    .hold_i(hold),
    .low_i(low),
    .hys_i(hys),
    .trip_i(trip),
    .ch_in_o(ch_in)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One bus cycle; the request is held until waitrequest is seen low.
  // Only the watchdog ends a wait that never gets its answer.
  task automatic bus(input logic w, input logic [4:0] a, input int d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
      @(posedge clk);
    while (wq !== 1'h0);
    rv = rdo;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  // Counts gate cycles of both channels, and pulldown and recover cycles of channel 0.
  task automatic run(input int cyc);
    hi = 0;
    hi1 = 0;
    pdc = 0;
    rec = 0;
    fpd = -1;
    for (int i = 0; i < cyc; i++)
    begin
      @(posedge clk);
      hi += int'(ch_out[0].gate === 1'h1);
      hi1 += int'(ch_out[1].gate === 1'h1);
      pdc += int'(ch_out[0].ea_pulldown === 1'h1);
      rec += int'(ch_out[0].soft_recover === 1'h1);
      if (fpd < 0 && ch_out[0].ea_pulldown === 1'h1)
        fpd = i;
    end
  endtask
  task automatic rst_seq(input int s);
    rst <= 1'h1;
    sel <= bphc_sel_t'(s);
    oc <= 1'h0;
    trip <= 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    bus(1'h1, `BPHC_OFS_CTRL, 3);
  endtask
  task automatic t_regs();
    rst_seq(0);
    bus(1'h0, `BPHC_OFS_DIV, 0);
    chk(rv, 32'h0000_0003);
    bus(1'h1, 5'h14, 1);
    bus(1'h0, 5'h14, 0);
    chk(rv, 32'h0000_0000);
    bus(1'h0, `BPHC_OFS_CTRL, 0);
    chk(rv, 32'h0000_0003);
    $display("test regs done");
  endtask
  task automatic t_duty();
    for (int i = 0; i < 3; i++)
    begin
      rst_seq(i);
      run(PER);
      run(2 * PER);
      chk(hi, 2 * ((PER * pct[i] + 99) / 100));
      chk(hi1, 2 * ((PER * pct[i] + 99) / 100));
      trip <= 8'h01;
      run(PER);
      run(2 * PER);
      chk(hi, 2 * (blk[i] + 1));
      chk(hi1, 2 * (blk[i] + 1));
    end
    $display("test duty done");
  endtask
  task automatic t_ov();
    rst_seq(0);
    ov <= 1'h1;
    run(2 * PER);
    chk(hi, 0);
    ov <= 1'h0;
    run(PER);
    run(2 * PER);
    chk(hi, 2 * ((PER * pct[0] + 99) / 100));
    chk(hi1, 2 * ((PER * pct[0] + 99) / 100));
    bus(1'h0, `BPHC_OFS_IRQ_STAT, 0);
    chk(rv, 32'h0000_0004);
    chk(irq, 1'h0);
    bus(1'h1, `BPHC_OFS_IRQ_MASK, 4);
    run(2);
    chk(irq, 1'h1);
    bus(1'h1, `BPHC_OFS_IRQ_STAT, 4);
    run(2);
    chk(irq, 1'h0);
    $display("test ov done");
  endtask
  task automatic t_hic();
    rst_seq(0);
    oc <= 1'h1;
    run(16 * PER + 4);
    chk(fpd >= 15 * PER && fpd <= 16 * PER, 1'h1);
    bus(1'h0, `BPHC_OFS_STATUS, 0);
    chk(rv[0], 1'h1);
    oc <= 1'h0;
    run(2 * PER);
    chk(ch_out[0].ea_pulldown, 1'h0);
    bus(1'h0, `BPHC_OFS_IRQ_STAT, 0);
    chk(rv, 32'h0000_0001);
    $display("test hiccup done");
  endtask
  task automatic t_clr();
    rst_seq(0);
    oc <= 1'h1;
    run(8 * PER);
    oc <= 1'h0;
    run(3 * PER);
    chk(rec, 1);
    bus(1'h0, `BPHC_OFS_STATUS, 0);
    chk(rv[12:8], 5'h00);
    bus(1'h0, `BPHC_OFS_IRQ_STAT, 0);
    chk(rv, 32'h0000_0010);
    oc <= 1'h1;
    run(12 * PER);
    chk(pdc, 0);
    $display("test clear done");
  endtask
  task automatic t_ss();
    rst_seq(0);
    hold <= 1'h1;
    oc <= 1'h1;
    run(18 * PER);
    chk(pdc, 0);
    hold <= 1'h0;
    run(2 * PER);
    chk(pdc > 0, 1'h1);
    $display("test soft-start done");
  endtask
  task automatic t_skip();
    rst_seq(0);
    low <= 1'h1;
    hys <= 1'h0;
    run(PER);
    run(2 * PER);
    chk(hi, 0);
    low <= 1'h0;
    run(2 * PER);
    chk(hi, 0);
    hys <= 1'h1;
    run(2 * PER);
    chk(hi > 0, 1'h1);
    $display("test skip done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Scenarios run one after another from a fresh reset each.
  initial
  begin
    t_regs();
    t_duty();
    t_ov();
    t_hic();
    t_clr();
    t_ss();
    t_skip();
    end_of_test();
  end
  // Watchdog well beyond the roughly 3500 cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
